// ### design/gei_port_irq.sv
`timescale 1ns/100ps
`include "gei_defines.svh"

// Summary of operation
// RL1: lines interrupt on edge chosen per bit
// RL2: edge bit xored before falling detector
// RL3: software sets edges before enabling channels
// RL4: direction zero makes pin hi-z input
// RL5: direction one makes pin push-pull output
// RL6: output pins drive written data bit
// RL7: read gives register for outputs, pins otherwise
// RL8: sixteen channels, sixteen distinct vectors
// RL9: vector placed on bus during acknowledge
// RL10: per-channel enable, mask, pending, in-service access
// RL11: vector register bit selects end-of-interrupt mode
// RL12: fixed bit map of channels in groups
// RL13: eight lines, each input or output
// RL14: channel code gives priority, fifteen highest
// RL15: vector is base nibble plus channel code
// RL16: zero write or acknowledge clears pending
// RL17: mask blocks request, pending still latches
// RL18: request when pending, unmasked, not blocked

module gei_port_irq (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // processor bus
   input wire logic bus_cs_n,
   input wire logic bus_ds_n,
   input wire logic bus_rw,
   input wire logic [4:0] bus_addr,
   input wire logic [7:0] bus_data_in,
   output logic [7:0] bus_data_out,
   output logic bus_data_oe_n,
   output logic dtack_n,
   output logic dtack_oe_n,
   // interrupt handshake and chain
   input wire logic irq_ack_n,
   input wire logic chain_enable_in_n,
   output logic chain_enable_out_n,
   output logic irq_request_n,
   output logic irq_request_oe_n,
   // port lines
   input wire logic [7:0] port_lines_in,
   output logic [7:0] port_lines_out,
   output logic [7:0] port_lines_oe_n,
   // internal source pulses, same clock, only non-line channels used
   input wire logic [15:0] source_event
);

   import gei_pkg::*;

   gei_bus_t bus_raw;
   gei_bus_t bus;
   gei_state_t state;
   logic [7:0] line_level;
   logic [7:0] line_event;
   logic [7:0] port_line_data;
   logic [7:0] active_edge_select;
   logic [7:0] line_direction;
   logic [15:0] irq_enable;
   logic [15:0] irq_pending;
   logic [15:0] irq_in_service;
   logic [15:0] irq_mask;
   logic [3:0] vector_base_register;
   logic soft_eoi;
   logic [15:0] chan_event;
   logic [15:0] blocked;
   logic [15:0] req_vec;
   logic any_req;
   logic [3:0] vector_channel_code;
   logic sel;
   logic wr_stb;
   logic rd_stb;
   logic ack_stb;
   logic drive_data;
   logic [15:0] next_irq_pending;
   logic [15:0] next_irq_in_service;
   logic [7:0] read_value;

   ////////////////////////////////////////////////////////////////////////////
   // pin capture

   assign bus_raw = {bus_cs_n, bus_ds_n, bus_rw, irq_ack_n, chain_enable_in_n,
                     bus_addr, bus_data_in};

   gei_sync3 #(.WIDTH($bits(gei_bus_t)), .RST_VAL(`GEI_BUS_IDLE)) u_bus_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(bus_raw),
      .q(bus)
   );

   gei_sync3 #(.WIDTH(8), .RST_VAL(`GEI_RST_BYTE)) u_line_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(port_lines_in),
      .q(line_level)
   );

   gei_edge_detect u_edge (
      .ref_clk(ref_clk),
      .rst(rst),
      .line_level(line_level),
      .edge_sel(active_edge_select),
      .line_event(line_event)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   assign sel = ~bus.cs_n & ~bus.ds_n & (state == gei_st_idle);
   assign wr_stb = sel & ~bus.rw;
   assign rd_stb = sel & bus.rw;
   // RL9 acknowledge accepted
   assign ack_stb = ~bus.irq_ack_n_n & ~bus.ds_n & ~bus.iei_n & bus.cs_n & any_req
                    & (state == gei_st_idle);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= gei_st_idle;
      end else begin
         case (state)
            gei_st_idle: begin
               if (wr_stb || rd_stb || ack_stb) begin
                  state <= gei_st_ack;
               end
            end
            gei_st_ack: begin
               if (bus.ds_n) begin
                  state <= gei_st_idle;
               end
            end
            default: begin
               state <= gei_st_idle;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // port registers

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         port_line_data <= `GEI_RST_BYTE;
         active_edge_select <= `GEI_RST_BYTE;
         line_direction <= `GEI_RST_BYTE;
      end else if (wr_stb) begin
         if (bus.addr == `GEI_OFS_DATA) begin
            port_line_data <= bus.wdata;
         end
         if (bus.addr == `GEI_OFS_EDGE) begin
            active_edge_select <= bus.wdata;
         end
         if (bus.addr == `GEI_OFS_DIR) begin
            line_direction <= bus.wdata;
         end
      end
   end

   // RL13 eight independent lines
   // RL4 zero is hi-z input
   // RL5 one is output
   assign port_lines_oe_n = ~line_direction;
   // RL6 output pins drive data
   assign port_lines_out = port_line_data;

   ////////////////////////////////////////////////////////////////////////////
   // channel control registers

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_enable <= `GEI_RST_CHAN;
         irq_mask <= `GEI_RST_CHAN;
         vector_base_register <= `GEI_RST_NIB;
         soft_eoi <= 1'b0;
      end else if (wr_stb) begin
         // RL10 enable and mask writes
         case (bus.addr)
            `GEI_OFS_IEN_A: irq_enable[`GEI_GRP_A_HI:`GEI_GRP_A_LO] <= bus.wdata;
            `GEI_OFS_IEN_B: irq_enable[`GEI_GRP_B_HI:`GEI_GRP_B_LO] <= bus.wdata;
            `GEI_OFS_IMASK_A: irq_mask[`GEI_GRP_A_HI:`GEI_GRP_A_LO] <= bus.wdata;
            `GEI_OFS_IMASK_B: irq_mask[`GEI_GRP_B_HI:`GEI_GRP_B_LO] <= bus.wdata;
            `GEI_OFS_VECT: begin
               vector_base_register <= bus.wdata[`GEI_VEC_BASE_HI:`GEI_VEC_BASE_LO];
               soft_eoi <= bus.wdata[`GEI_VEC_SOFT_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel events and priority

   // RL12 line and source channel map
   assign chan_event = {line_event[7:6], source_event[13:8], line_event[5:4],
                        source_event[5:4], line_event[3:0]};

   // RL18 block at or below a channel in service
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_chan
         assign blocked[g] = |irq_in_service[15:g];
      end
   endgenerate

   // RL17 mask gates request only
   assign req_vec = irq_pending & irq_enable & irq_mask & ~blocked;
   assign any_req = |req_vec;

   // RL14 highest code wins
   function automatic logic [3:0] top_code(input logic [15:0] v);
      top_code = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) begin
            top_code = i[3:0];
         end
      end
   endfunction

   // RL8 one code per channel
   assign vector_channel_code = top_code(req_vec);

   ////////////////////////////////////////////////////////////////////////////
   // pending and in-service

   always_comb begin
      next_irq_pending = irq_pending;
      // RL16 zero write clears
      if (wr_stb && bus.addr == `GEI_OFS_IPEND_A) begin
         next_irq_pending[`GEI_GRP_A_HI:`GEI_GRP_A_LO] =
            irq_pending[`GEI_GRP_A_HI:`GEI_GRP_A_LO] & bus.wdata;
      end
      if (wr_stb && bus.addr == `GEI_OFS_IPEND_B) begin
         next_irq_pending[`GEI_GRP_B_HI:`GEI_GRP_B_LO] =
            irq_pending[`GEI_GRP_B_HI:`GEI_GRP_B_LO] & bus.wdata;
      end
      // RL16 acknowledge clears
      if (ack_stb) begin
         next_irq_pending[vector_channel_code] = 1'b0;
      end
      // a new edge wins over a clear in the same cycle; disabling clears
      next_irq_pending = (next_irq_pending | (chan_event & irq_enable)) & irq_enable;
   end

   always_comb begin
      next_irq_in_service = irq_in_service;
      if (wr_stb && bus.addr == `GEI_OFS_ISRV_A) begin
         next_irq_in_service[`GEI_GRP_A_HI:`GEI_GRP_A_LO] =
            irq_in_service[`GEI_GRP_A_HI:`GEI_GRP_A_LO] & bus.wdata;
      end
      if (wr_stb && bus.addr == `GEI_OFS_ISRV_B) begin
         next_irq_in_service[`GEI_GRP_B_HI:`GEI_GRP_B_LO] =
            irq_in_service[`GEI_GRP_B_HI:`GEI_GRP_B_LO] & bus.wdata;
      end
      if (ack_stb) begin
         next_irq_in_service[vector_channel_code] = 1'b1;
      end
      // RL11 automatic mode holds in-service clear
      if (!soft_eoi) begin
         next_irq_in_service = `GEI_RST_CHAN;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_pending <= `GEI_RST_CHAN;
         irq_in_service <= `GEI_RST_CHAN;
      end else begin
         irq_pending <= next_irq_pending;
         irq_in_service <= next_irq_in_service;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data and vector

   always_comb begin
      case (bus.addr)
         // RL7 outputs from register, inputs from pins
         `GEI_OFS_DATA: read_value = (line_direction & port_line_data)
                                     | (~line_direction & line_level);
         `GEI_OFS_EDGE: read_value = active_edge_select;
         `GEI_OFS_DIR: read_value = line_direction;
         `GEI_OFS_IEN_A: read_value = irq_enable[`GEI_GRP_A_HI:`GEI_GRP_A_LO];
         `GEI_OFS_IEN_B: read_value = irq_enable[`GEI_GRP_B_HI:`GEI_GRP_B_LO];
         `GEI_OFS_IPEND_A: read_value = irq_pending[`GEI_GRP_A_HI:`GEI_GRP_A_LO];
         `GEI_OFS_IPEND_B: read_value = irq_pending[`GEI_GRP_B_HI:`GEI_GRP_B_LO];
         `GEI_OFS_ISRV_A: read_value = irq_in_service[`GEI_GRP_A_HI:`GEI_GRP_A_LO];
         `GEI_OFS_ISRV_B: read_value = irq_in_service[`GEI_GRP_B_HI:`GEI_GRP_B_LO];
         `GEI_OFS_IMASK_A: read_value = irq_mask[`GEI_GRP_A_HI:`GEI_GRP_A_LO];
         `GEI_OFS_IMASK_B: read_value = irq_mask[`GEI_GRP_B_HI:`GEI_GRP_B_LO];
         `GEI_OFS_VECT: read_value = {vector_base_register, soft_eoi, 3'h0};
         default: read_value = `GEI_RST_BYTE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus_data_out <= `GEI_RST_BYTE;
         drive_data <= 1'b0;
      end else if (ack_stb) begin
         // RL15 base nibble and code
         bus_data_out <= {vector_base_register, vector_channel_code};
         drive_data <= 1'b1;
      end else if (rd_stb) begin
         bus_data_out <= read_value;
         drive_data <= 1'b1;
      end else if (wr_stb) begin
         drive_data <= 1'b0;
      end
   end

   // the data bus is only driven while dtack is, so no fight at release
   assign bus_data_oe_n = ~(drive_data & (state == gei_st_ack));
   assign dtack_n = ~(state == gei_st_ack);
   assign dtack_oe_n = ~(state == gei_st_ack);

   // RL18 open-drain request
   assign irq_request_n = 1'b0;
   assign irq_request_oe_n = ~(any_req & bus.irq_ack_n_n & (state == gei_st_idle));
   assign chain_enable_out_n = ~(~bus.iei_n & ~any_req & (state == gei_st_idle));

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   edge_pend_set_a: assert property ( // RL1
      |(chan_event & irq_enable) |=> ((irq_pending & $past(chan_event & irq_enable))
                                      == $past(chan_event & irq_enable)))
      else $error("enabled edge did not set pending");

   dir_write_oe_a: assert property ( // RL4
      wr_stb && bus.addr == `GEI_OFS_DIR |=> port_lines_oe_n == ~$past(bus.wdata))
      else $error("direction write not seen on output enable");

   data_write_pin_a: assert property ( // RL6
      wr_stb && bus.addr == `GEI_OFS_DATA |=> port_lines_out == $past(bus.wdata))
      else $error("data write not driven on pins");

   port_read_mix_a: assert property ( // RL7
      rd_stb && bus.addr == `GEI_OFS_DATA |=> bus_data_out ==
         (($past(line_direction) & $past(port_line_data))
          | (~$past(line_direction) & $past(line_level))))
      else $error("port read mixed wrongly");

   vector_out_a: assert property ( // RL15
      ack_stb |=> bus_data_out == {$past(vector_base_register), $past(vector_channel_code)}
                  && !bus_data_oe_n && !dtack_n)
      else $error("vector not presented on acknowledge");

   ack_clear_pend_a: assert property ( // RL16
      ack_stb && !chan_event[vector_channel_code] |=>
         !irq_pending[$past(vector_channel_code)])
      else $error("acknowledge left pending set");

   mask_blocks_req_a: assert property ( // RL17
      (irq_pending & irq_mask) == `GEI_RST_CHAN |-> irq_request_oe_n)
      else $error("masked channel requested");

   auto_eoi_clear_a: assert property ( // RL11
      !soft_eoi |=> irq_in_service == `GEI_RST_CHAN)
      else $error("in-service kept in automatic mode");

   req_not_blocked_a: assert property ( // RL18
      !irq_request_oe_n |-> irq_pending[vector_channel_code]
         && irq_enable[vector_channel_code]
         && irq_mask[vector_channel_code]
         && (irq_in_service >> vector_channel_code) == `GEI_RST_CHAN)
      else $error("request without eligible channel");

   ack_cover_c: cover property (ack_stb ##1 state == gei_st_ack ##[1:20] state == gei_st_idle);
   soft_ack_cover_c: cover property (soft_eoi && ack_stb);
   pend_write_cover_c: cover property (wr_stb && bus.addr == `GEI_OFS_IPEND_A);
   port_read_cover_c: cover property (rd_stb && bus.addr == `GEI_OFS_DATA);

endmodule // gei_port_irq

// ### include/gei_defines.svh
`ifndef GEI_DEFINES_SVH
`define GEI_DEFINES_SVH

// register offsets on the five address lines
`define GEI_OFS_DATA 5'h00
`define GEI_OFS_EDGE 5'h01
`define GEI_OFS_DIR 5'h02
`define GEI_OFS_IEN_A 5'h03
`define GEI_OFS_IEN_B 5'h04
`define GEI_OFS_IPEND_A 5'h05
`define GEI_OFS_IPEND_B 5'h06
`define GEI_OFS_ISRV_A 5'h07
`define GEI_OFS_ISRV_B 5'h08
`define GEI_OFS_IMASK_A 5'h09
`define GEI_OFS_IMASK_B 5'h0A
`define GEI_OFS_VECT 5'h0B

// reset values
`define GEI_RST_BYTE 8'h00
`define GEI_RST_CHAN 16'h0000
`define GEI_RST_NIB 4'h0
// bus inputs idle high: cs_n, ds_n, rw, irq_ack_n_n, iei_n
`define GEI_BUS_IDLE 18'h3E000

// vector register fields
`define GEI_VEC_BASE_HI 7
`define GEI_VEC_BASE_LO 4
`define GEI_VEC_SOFT_BIT 3

// channel groups: group a is the upper half
`define GEI_GRP_A_HI 15
`define GEI_GRP_A_LO 8
`define GEI_GRP_B_HI 7
`define GEI_GRP_B_LO 0

`endif

// ### include/gei_pkg.sv
package gei_pkg;

   // synchronised view of the processor bus pins
   typedef struct packed {
      logic cs_n;
      logic ds_n;
      logic rw;
      logic irq_ack_n_n;
      logic iei_n;
      logic [4:0] addr;
      logic [7:0] wdata;
   } gei_bus_t;

   typedef enum logic [1:0] {
      gei_st_idle = 2'b01,
      gei_st_ack = 2'b10
   } gei_state_t;

endpackage

// ### design/gei_sync3.sv
`timescale 1ns/100ps

module gei_sync3 #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // asynchronous in, filtered out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a bit only moves once two stages agree, so a late glitch is not taken
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               q[i] <= RST_VAL[i];
            end else if (s2[i] == s3[i]) begin
               q[i] <= s2[i];
            end
         end
      end
   endgenerate

endmodule // gei_sync3

// ### design/gei_edge_detect.sv
`timescale 1ns/100ps
`include "gei_defines.svh"

module gei_edge_detect (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // filtered lines and edge choice
   input wire logic [7:0] line_level,
   input wire logic [7:0] edge_sel,
   // one-cycle event per line
   output logic [7:0] line_event
);

   logic [7:0] xored;
   logic [7:0] xored_q;

   // RL2 xor then falling
   assign xored = line_level ^ edge_sel;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         xored_q <= `GEI_RST_BYTE;
      end else begin
         xored_q <= xored;
      end
   end

   // RL1 falling or rising
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_line
         assign line_event[i] = xored_q[i] & ~xored[i];
      end
   endgenerate

endmodule // gei_edge_detect

// ### testbench/gei_host_model.sv
`timescale 1ns/100ps

module gei_host_model (
   // clock
   input wire logic ref_clk,
   // requests towards the device
   output logic bus_cs_n,
   output logic bus_ds_n,
   output logic bus_rw,
   output logic [4:0] bus_addr,
   output logic [7:0] bus_data_in,
   output logic irq_ack_n,
   output logic chain_enable_in_n,
   // answers from the device
   input wire logic [7:0] bus_data_out,
   input wire logic bus_data_oe_n,
   input wire logic dtack_n,
   input wire logic dtack_oe_n
);
   logic [7:0] wd;
   logic drv;
   logic dtack_w;
   // a released data bus shows the inverse of the last value, never a held copy
   assign bus_data_in = !bus_data_oe_n ? bus_data_out : (drv ? wd : ~wd);
   // acknowledge pin is pulled up while nobody drives it
   assign dtack_w = dtack_oe_n ? 1'b1 : dtack_n;
   initial begin
      bus_cs_n = 1'b1;
      bus_ds_n = 1'b1;
      bus_rw = 1'b1;
      bus_addr = 5'h00;
      wd = 8'h00;
      drv = 1'b0;
      irq_ack_n = 1'b1;
      chain_enable_in_n = 1'b0;
   end
   ////////////////////////////////////////
   // request held until acknowledge is sampled low or 30 clocks pass, then released
   task automatic cycle(input logic ak, output logic got, output logic [7:0] r);
      got = 1'b0;
      bus_ds_n = 1'b0;
      if (ak) begin
         irq_ack_n = 1'b0;
      end else begin
         bus_cs_n = 1'b0;
      end
      for (int i = 0; i < 30 && !got; i++) begin
         @(posedge ref_clk);
         got = (dtack_w === 1'b0);
      end
      r = bus_data_in;
      #1;
      bus_ds_n = 1'b1;
      bus_cs_n = 1'b1;
      irq_ack_n = 1'b1;
      bus_rw = 1'b1;
      drv = 1'b0;
      for (int i = 0; i < 30 && dtack_w === 1'b0; i++) begin
         @(posedge ref_clk);
      end
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic g;
      logic [7:0] r;
      bus_addr = a;
      bus_rw = 1'b0;
      wd = d;
      drv = 1'b1;
      cycle(1'b0, g, r);
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] r);
      logic g;
      bus_addr = a;
      bus_rw = 1'b1;
      cycle(1'b0, g, r);
   endtask
   task automatic ack(output logic g, output logic [7:0] r);
      cycle(1'b1, g, r);
   endtask
endmodule // gei_host_model

// ### testbench/gei_port_irq_tb_top.sv
`timescale 1ns/100ps

module gei_port_irq_tb_top;
   import gei_pkg::*;
   logic ref_clk, rst, bus_cs_n, bus_ds_n, bus_rw, bus_data_oe_n, dtack_n, dtack_oe_n;
   logic irq_ack_n, chain_enable_in_n, chain_enable_out_n, irq_request_n, irq_request_oe_n;
   logic [4:0] bus_addr;
   logic [7:0] bus_data_in, bus_data_out, pin_tb, port_lines_in, port_lines_out;
   logic [7:0] port_lines_oe_n;
   logic [15:0] source_event;
   logic irq_w;
   int err_total, total_checks;
   logic [4:0] rw_ofs [7] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h09, 5'h0A, 5'h0B};
   assign irq_w = irq_request_oe_n ? 1'b1 : irq_request_n;
   assign port_lines_in = (port_lines_out & ~port_lines_oe_n) | (pin_tb & port_lines_oe_n);
   gei_port_irq dut (.ref_clk, .rst, .bus_cs_n, .bus_ds_n, .bus_rw, .bus_addr, .bus_data_in,
      .bus_data_out, .bus_data_oe_n, .dtack_n, .dtack_oe_n, .irq_ack_n, .chain_enable_in_n,
      .chain_enable_out_n, .irq_request_n, .irq_request_oe_n, .port_lines_in,
      .port_lines_out, .port_lines_oe_n, .source_event);
   gei_host_model host (.ref_clk, .bus_cs_n, .bus_ds_n, .bus_rw, .bus_addr, .bus_data_in,
      .irq_ack_n, .chain_enable_in_n, .bus_data_out, .bus_data_oe_n, .dtack_n, .dtack_oe_n);
   ////////////////////////////////////////
   function automatic logic [15:0] chan_bit(int ln);
      return 16'h0001 << (ln > 5 ? ln + 8 : (ln > 3 ? ln + 2 : ln));
   endfunction
   function automatic logic [3:0] top_code(logic [15:0] p);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (p[i]) c = 4'(i);
      end
      return c;
   endfunction
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      total_checks++;
      if (got !== ex) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic rd16(input logic [4:0] a, output logic [15:0] r);
      host.rd(a, r[15:8]);
      host.rd(a + 5'h01, r[7:0]);
   endtask
   task automatic en_all(input logic [7:0] x);
      foreach (rw_ofs[k]) begin
         if (k > 1 && k < 6) host.wr(rw_ofs[k], x);
      end
   endtask
   task automatic clr_pend();
      host.wr(5'h05, 8'h00);
      host.wr(5'h06, 8'h00);
   endtask
   task automatic pulse(input logic [15:0] x);
      source_event = x;
      @(posedge ref_clk);
      #1 source_event = 16'h0000;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic settle();
      repeat (10) @(posedge ref_clk);
      #1;
   endtask
   ////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // about 270 bus cycles of a dozen clocks each, with wide margin
   initial begin
      #2000000;
      err_total++;
      results();
   end
   initial begin
      logic [7:0] v, e;
      logic [15:0] p, m, x;
      logic g;
      rst = 1'b1;
      pin_tb = 8'h00;
      source_event = 16'h0000;
      err_total = 0;
      total_checks = 0;
      v = 8'($urandom(65330));
      repeat (2) @(posedge ref_clk);
      #1 rst = 1'b0;
      settle();
      for (int a = 0; a < 13; a++) begin
         host.rd(5'(a), v);
         chk("reset reg", 16'h0000, 16'(v));
      end
      host.rd(5'h1F, v);
      chk("unmapped", 16'h0000, 16'(v));
      chk("line oe", 16'h00FF, 16'(port_lines_oe_n));
      foreach (rw_ofs[k]) begin
         e = 8'($urandom);
         host.wr(rw_ofs[k], e);
         host.rd(rw_ofs[k], v);
         chk("reg rw", 16'(k == 6 ? e & 8'hF8 : e), 16'(v));
      end
      foreach (rw_ofs[k]) host.wr(rw_ofs[k], 8'h00);
      $display("test registers done");
      repeat (8) begin
         v = 8'($urandom);
         e = 8'($urandom);
         pin_tb = 8'($urandom);
         host.wr(5'h02, v);
         host.wr(5'h00, e);
         chk("line oe", {8'h00, ~v}, 16'(port_lines_oe_n));
         chk("line out", 16'(e & v), 16'(port_lines_out & v));
         host.rd(5'h00, p[7:0]);
         chk("port read", 16'((e & v) | (pin_tb & ~v)), 16'(p[7:0]));
      end
      host.wr(5'h02, 8'h00);
      $display("test port done");
      for (int ed = 0; ed < 2; ed++) begin
         pin_tb = ed ? 8'h00 : 8'hFF;
         // edges are set before channels are enabled
         host.wr(5'h01, ed ? 8'hFF : 8'h00);
         en_all(8'hFF);
         settle();
         clr_pend();
         for (int i = 0; i < 8; i++) begin
            pin_tb[i] = ~pin_tb[i];
            settle();
            rd16(5'h05, p);
            chk("line pending", chan_bit(i), p);
            chk("request", 16'h0000, 16'(irq_w));
            chk("chain out", 16'h0001, 16'(chain_enable_out_n));
            clr_pend();
            // the return edge must not latch anything
            pin_tb[i] = ~pin_tb[i];
            settle();
            rd16(5'h05, p);
            chk("wrong edge", 16'h0000, p);
            chk("request", 16'h0001, 16'(irq_w));
            chk("chain out", 16'h0000, 16'(chain_enable_out_n));
         end
         en_all(8'h00);
      end
      host.wr(5'h01, 8'h00);
      pin_tb = 8'hFF;
      en_all(8'hFF);
      settle();
      clr_pend();
      host.wr(5'h01, 8'h01);
      settle();
      rd16(5'h05, p);
      chk("edge flip", 16'h0001, p);
      clr_pend();
      $display("test edges done");
      repeat (4) begin
         e = 8'($urandom);
         m = 16'($urandom);
         host.wr(5'h0B, e & 8'hF0);
         host.wr(5'h09, m[15:8]);
         host.wr(5'h0A, m[7:0]);
         x = 16'($urandom) & 16'h3F30;
         pulse(x);
         p = x & m;
         while (p != 16'h0000) begin
            host.ack(g, v);
            chk("vector", 16'({e[7:4], top_code(p)}), 16'(v));
            p[top_code(p)] = 1'b0;
         end
         host.ack(g, v);
         chk("no answer", 16'h0000, 16'(g));
         rd16(5'h05, p);
         chk("masked pending", x & ~m, p);
         host.wr(5'h09, 8'hFF);
         host.wr(5'h0A, 8'hFF);
         chk("request", 16'((x & ~m) == 16'h0000), 16'(irq_w));
         host.wr(5'h05, 8'hFF);
         rd16(5'h05, p);
         chk("pending keep", x & ~m, p);
         clr_pend();
      end
      $display("test acknowledge done");
      host.wr(5'h0B, 8'h58);
      pulse(16'h0200);
      host.ack(g, v);
      chk("vector", 16'h0059, 16'(v));
      host.rd(5'h07, v);
      chk("in service", 16'h0002, 16'(v));
      pulse(16'h0100);
      chk("request", 16'h0001, 16'(irq_w));
      pulse(16'h1000);
      host.ack(g, v);
      chk("vector", 16'h005C, 16'(v));
      host.wr(5'h07, 8'hEF);
      host.ack(g, v);
      chk("no answer", 16'h0000, 16'(g));
      host.wr(5'h07, 8'h00);
      host.ack(g, v);
      chk("vector", 16'h0058, 16'(v));
      host.rd(5'h07, v);
      chk("in service", 16'h0001, 16'(v));
      $display("test end of interrupt done");
      results();
   end
endmodule // gei_port_irq_tb_top
